// ==== design/slt_serial_link_tx.v ====
// Purpose: Link layer of an eight channel serial transmitter with its configuration registers
// Assumes: Registers reached through the serial port core's internal strobes; one octet per lane per clock
// Notes: Eight converters fixed; samples arrive as offset binary, 14 bits each, channel A lowest
`timescale 1ns/10ps
`include "slt_defs.vh"
`default_nettype none
module slt_serial_link_tx (
	input wire sys_clk_in,
	input wire rst_n_in,
	input wire ce_in,
	input wire [12:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output wire [7:0] reg_rdata_out,
	input wire [111:0] sample_data_in,
	input wire sample_valid_in,
	output wire sample_ready_out,
	input wire sync_request_input_in,
	input wire [3:0] zstuff_ratio_in,
	output wire [9:0] first_serial_lane_out,
	output wire [9:0] second_serial_lane_out,
	output wire [9:0] third_serial_lane_out,
	output wire [9:0] fourth_serial_lane_out,
	output wire [3:0] lane_enable_out,
	output wire [1:0] link_state_out
);
localparam ST_OFF = 2'd0;
localparam ST_CGS = 2'd1;
localparam ST_ILAS = 2'd2;
localparam ST_DATA = 2'd3;
// ****************
// Functions
// ****************
function [5:0] t6;
	input [4:0] x;
	case (x)
	5'd0: t6 = 6'b100111; 5'd1: t6 = 6'b011101; 5'd2: t6 = 6'b101101; 5'd3: t6 = 6'b110001;
	5'd4: t6 = 6'b110101; 5'd5: t6 = 6'b101001; 5'd6: t6 = 6'b011001; 5'd7: t6 = 6'b111000;
	5'd8: t6 = 6'b111001; 5'd9: t6 = 6'b100101; 5'd10: t6 = 6'b010101; 5'd11: t6 = 6'b110100;
	5'd12: t6 = 6'b001101; 5'd13: t6 = 6'b101100; 5'd14: t6 = 6'b011100; 5'd15: t6 = 6'b010111;
	5'd16: t6 = 6'b011011; 5'd17: t6 = 6'b100011; 5'd18: t6 = 6'b010011; 5'd19: t6 = 6'b110010;
	5'd20: t6 = 6'b001011; 5'd21: t6 = 6'b101010; 5'd22: t6 = 6'b011010; 5'd23: t6 = 6'b111010;
	5'd24: t6 = 6'b110011; 5'd25: t6 = 6'b100110; 5'd26: t6 = 6'b010110; 5'd27: t6 = 6'b110110;
	5'd28: t6 = 6'b001110; 5'd29: t6 = 6'b101110; 5'd30: t6 = 6'b011110; default: t6 = 6'b101011;
	endcase
endfunction
function [3:0] t4;
	input [2:0] y;
	case (y)
	3'd0: t4 = 4'b1011; 3'd1: t4 = 4'b1001; 3'd2: t4 = 4'b0101; 3'd3: t4 = 4'b1100;
	3'd4: t4 = 4'b1101; 3'd5: t4 = 4'b1010; 3'd6: t4 = 4'b0110; default: t4 = 4'b1110;
	endcase
endfunction
// Only K28 control characters are used, so the control path forces the 6b code
function [10:0] enc;
	input [7:0] d;
	input k;
	input rd;
	reg [5:0] c6;
	reg [3:0] c4;
	reg b6, b4, bk, r1, a7;
	begin
		c6 = k ? 6'b001111 : t6(d[4:0]);
		b6 = ((c6[0] + c6[1] + c6[2] + c6[3] + c6[4] + c6[5]) == 3);
		if (rd && (!b6 || (d[4:0] == 5'd7 && !k)))
			c6 = ~c6;
		r1 = b6 ? rd : ~rd;
		a7 = (d[7:5] == 3'd7) && (k || (!r1 && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20))
			|| (r1 && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14)));
		c4 = a7 ? 4'b0111 : t4(d[7:5]);
		bk = (d[7:5] == 3'd1) || (d[7:5] == 3'd2) || (d[7:5] == 3'd5) || (d[7:5] == 3'd6);
		b4 = bk || (d[7:5] == 3'd3);
		if ((k && bk) ? !r1 : (r1 && (!b4 || d[7:5] == 3'd3)))
			c4 = ~c4;
		enc = {b4 ? r1 : ~r1, c6, c4};
	end
endfunction
// Self synchronising 1 + x^14 + x^15, most significant bit first
function [22:0] scr8;
	input [14:0] st;
	input [7:0] d;
	integer i;
	reg s;
	begin
		scr8 = 23'h0;
		for (i = 7; i >= 0; i = i - 1)
		begin
			s = d[i] ^ st[14] ^ st[13];
			st = {st[13:0], s};
			scr8[i] = s;
		end
		scr8[22:8] = st;
	end
endfunction
function [13:0] fmt14;
	input [13:0] s;
	input [1:0] m;
	case (m)
	2'b01: fmt14 = {~s[13], s[12:0]};
	2'b10: fmt14 = s ^ {1'b0, s[13:1]};
	default: fmt14 = s;
	endcase
endfunction
// ****************
// Registers
// ****************
reg [7:0] fmt_r, drv_r, lctl_r, mir_r, rep_r, did_r, lcfg_r, rdata_r;
reg [3:0] bid_r;
reg [19:0] lid_r;
reg [4:0] k_r;
reg sopt_r;
wire [1:0] lsel = {lcfg_r[1], lcfg_r[0] & ~lcfg_r[1]};
wire [4:0] f_m1 = 5'd15 >> lsel;
wire [1:0] ilas_mode = lctl_r[3:2];
wire lane_sync = (ilas_mode != 2'b01);
wire scr_en = lcfg_r[`SLT_B_SCR];
function [7:0] config_checksum;
	input [4:0] lane1_ident_value;
	config_checksum = did_r + bid_r + lane1_ident_value + scr_en + {lcfg_r[1], lcfg_r[0]} + f_m1 + k_r + `SLT_M_M1
		+ `SLT_N_M1 + `SLT_NP_M1 + `SLT_CF;
endfunction
function [7:0] cfg_oct;
	input [3:0] idx;
	input [4:0] lane1_ident_value;
	case (idx)
	4'd0: cfg_oct = did_r;
	4'd1: cfg_oct = {4'h0, bid_r};
	4'd2: cfg_oct = {3'h0, lane1_ident_value};
	4'd3: cfg_oct = {scr_en, 5'h0, lcfg_r[1], lcfg_r[0]};
	4'd4: cfg_oct = {3'h0, f_m1};
	4'd5: cfg_oct = {3'h0, k_r};
	4'd6: cfg_oct = `SLT_M_M1;
	4'd7: cfg_oct = {3'h0, `SLT_N_M1};
	4'd8: cfg_oct = {3'h0, `SLT_NP_M1};
	4'd9: cfg_oct = 8'h00;
	4'd10: cfg_oct = {3'h0, `SLT_CF};
	4'd13: cfg_oct = config_checksum(lane1_ident_value);
	default: cfg_oct = 8'h00;
	endcase
endfunction
always @(posedge sys_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		fmt_r <= `SLT_R_OUTFMT;
		drv_r <= 8'h00;
		lctl_r <= `SLT_R_LCTL;
		mir_r <= 8'h00;
		rep_r <= 8'h00;
		did_r <= 8'h00;
		bid_r <= 4'h0;
		lid_r <= 20'h0;
		lcfg_r <= `SLT_R_LCFG;
		k_r <= `SLT_R_FPM;
		sopt_r <= 1'b0;
		rdata_r <= 8'h00;
	end
	else if (ce_in)
	begin
		if (reg_wr_in)
		begin
			case (reg_addr_in)
			`SLT_A_OUTFMT: fmt_r <= reg_wdata_in;
			`SLT_A_DRV: drv_r <= reg_wdata_in;
			`SLT_A_LCTL: lctl_r <= reg_wdata_in;
			`SLT_A_MIR: mir_r <= reg_wdata_in;
			`SLT_A_REP: rep_r <= reg_wdata_in;
			`SLT_A_DEVID: did_r <= reg_wdata_in;
			`SLT_A_BANKID: bid_r <= reg_wdata_in[3:0];
			`SLT_A_LANEID0: lid_r[4:0] <= reg_wdata_in[4:0];
			`SLT_A_LANEID1: lid_r[9:5] <= reg_wdata_in[4:0];
			`SLT_A_LANEID2: lid_r[14:10] <= reg_wdata_in[4:0];
			`SLT_A_LANEID3: lid_r[19:15] <= reg_wdata_in[4:0];
			`SLT_A_LCFG: lcfg_r <= reg_wdata_in;
			`SLT_A_FPM: k_r <= reg_wdata_in[4:0];
			`SLT_A_SOPT: sopt_r <= reg_wdata_in[`SLT_B_SYNCINV];
			default: ;
			endcase
		end
		if (reg_rd_in)
		begin
			case (reg_addr_in)
			`SLT_A_OUTFMT: rdata_r <= fmt_r;
			`SLT_A_DRV: rdata_r <= drv_r;
			`SLT_A_LCTL: rdata_r <= lctl_r;
			`SLT_A_MIR: rdata_r <= mir_r;
			`SLT_A_REP: rdata_r <= rep_r;
			`SLT_A_DEVID: rdata_r <= did_r;
			`SLT_A_BANKID: rdata_r <= {4'h0, bid_r};
			`SLT_A_LANEID0: rdata_r <= {3'h0, lid_r[4:0]};
			`SLT_A_LANEID1: rdata_r <= {3'h0, lid_r[9:5]};
			`SLT_A_LANEID2: rdata_r <= {3'h0, lid_r[14:10]};
			`SLT_A_LANEID3: rdata_r <= {3'h0, lid_r[19:15]};
			`SLT_A_LCFG: rdata_r <= lcfg_r;
			`SLT_A_OPF: rdata_r <= {3'h0, f_m1};
			`SLT_A_FPM: rdata_r <= {3'h0, k_r};
			`SLT_A_CPL: rdata_r <= `SLT_M_M1;
			`SLT_A_BPS: rdata_r <= {3'h0, `SLT_NP_M1};
			`SLT_A_SOPT: rdata_r <= {2'b00, sopt_r, 5'h00};
			`SLT_A_CWPF: rdata_r <= {3'h0, `SLT_CF};
			`SLT_A_CHK0: rdata_r <= config_checksum(lid_r[4:0]);
			`SLT_A_CHK1: rdata_r <= config_checksum(lid_r[9:5]);
			default: rdata_r <= 8'h00;
			endcase
		end
	end
end
assign reg_rdata_out = rdata_r;
// ****************
// Two-entry sample buffer
// ****************
reg [111:0] b0_r, b1_r, b0_nxt, b1_nxt;
reg [1:0] cnt_r, cnt_nxt;
reg rdy_r;
reg pop_w;
wire push_w = sample_valid_in & rdy_r;
always @*
begin
	b0_nxt = b0_r;
	b1_nxt = b1_r;
	cnt_nxt = cnt_r;
	case ({push_w, pop_w})
	2'b10:
	begin
		if (cnt_r == 2'd0)
			b0_nxt = sample_data_in;
		else
			b1_nxt = sample_data_in;
		cnt_nxt = cnt_r + 2'd1;
	end
	2'b01:
	begin
		b0_nxt = b1_r;
		cnt_nxt = cnt_r - 2'd1;
	end
	2'b11:
	begin
		b0_nxt = (cnt_r == 2'd1) ? sample_data_in : b1_r;
		b1_nxt = sample_data_in;
	end
	default: ;
	endcase
end
// ****************
// Link sequencing
// ****************
reg [1:0] st_r, mf_r;
reg [4:0] oct_r, fr_r;
reg [9:0] mfo_r;
reg [7:0] rc_r;
reg [3:0] zs_r;
reg [15:0] prn_r;
reg [111:0] cur_r;
reg [39:0] sym_r, sym_nxt;
reg [3:0] rd_r, rd_nxt, act_nxt, act_r;
reg [59:0] scr_r, scr_nxt;
reg [31:0] prev_r, prev_nxt;
wire sync_req = sync_request_input_in ^ ~sopt_r;
wire oct_last = (oct_r == f_m1);
wire mf_end = oct_last && (fr_r == k_r);
wire link_off = lctl_r[`SLT_B_LINKOFF];
wire [111:0] samp_w = (oct_r == 5'd0) ? (pop_w ? b0_r : 112'h0) : cur_r;
integer p, ch;
reg [1:0] g;
reg [15:0] w;
reg [7:0] o;
reg kf;
reg [22:0] sr;
reg [10:0] e;
reg [9:0] s10;
always @*
begin
	pop_w = (st_r == ST_DATA) && (oct_r == 5'd0) && (zs_r == 4'd0) && (cnt_r != 2'd0);
	sym_nxt = sym_r;
	rd_nxt = rd_r;
	scr_nxt = scr_r;
	prev_nxt = prev_r;
	act_nxt = 4'h0;
	g = 2'd0;
	w = 16'h0;
	o = 8'h0;
	kf = 1'b0;
	sr = 23'h0;
	e = 11'h0;
	s10 = 10'h0;
	ch = 0;
	for (p = 0; p < 4; p = p + 1)
	begin
		act_nxt[p] = (st_r != ST_OFF) && ((lsel == 2'd2) || (p == 0) || (lsel == 2'd1 && p == 2));
		g = (lsel == 2'd1) ? p[2:1] : p[1:0];
		ch = ({3'd0, g} << (3 - lsel)) + (oct_r >> 1);
		// Idle lanes fold back into range; their symbols are discarded anyway
		ch = ch & 7;
		w = {fmt14(samp_w[ch * 14 +: 14], fmt_r[1:0]), lctl_r[`SLT_B_TAILPRN] ? prn_r[2 * ch +: 2] : 2'b00};
		o = oct_r[0] ? w[7:0] : w[15:8];
		kf = 1'b0;
		case (st_r)
		ST_CGS:
		begin
			o = `SLT_K_K;
			kf = 1'b1;
		end
		ST_ILAS:
		begin
			o = mfo_r[7:0];
			kf = 1'b0;
			if (mfo_r == 10'd0)
			begin
				o = `SLT_K_R;
				kf = 1'b1;
			end
			else if (mf_end)
			begin
				o = `SLT_K_A;
				kf = 1'b1;
			end
			else if (mf_r == 2'd1 && mfo_r == 10'd1)
			begin
				o = `SLT_K_Q;
				kf = 1'b1;
			end
			else if (mf_r == 2'd1 && mfo_r < 10'd16)
				o = cfg_oct(mfo_r[3:0] - 4'd2, lid_r[p * 5 +: 5]);
		end
		ST_DATA:
		begin
			if (scr_en)
			begin
				sr = scr8(scr_r[p * 15 +: 15], o);
				scr_nxt[p * 15 +: 15] = sr[22:8];
				o = sr[7:0];
			end
			if (oct_last)
			begin
				prev_nxt[p * 8 +: 8] = o;
				if (!scr_en && o == prev_r[p * 8 +: 8])
				begin
					o = (mf_end && lane_sync) ? `SLT_K_A : `SLT_K_F;
					kf = 1'b1;
				end
				else if (scr_en && mf_end && lane_sync && o == `SLT_K_A)
					kf = 1'b1;
				else if (scr_en && (!mf_end || !lane_sync) && o == `SLT_K_F)
					kf = 1'b1;
			end
		end
		default: ;
		endcase
		e = enc(o, kf, rd_r[p]);
		s10 = e[9:0] ^ {10{fmt_r[`SLT_B_POLINV]}};
		if (mir_r[0])
			s10 = {s10[0], s10[1], s10[2], s10[3], s10[4], s10[5], s10[6], s10[7], s10[8], s10[9]};
		if (act_nxt[p] && st_r != ST_OFF)
		begin
			sym_nxt[p * 10 +: 10] = s10;
			rd_nxt[p] = e[10];
		end
		else
		begin
			sym_nxt[p * 10 +: 10] = 10'h000;
			rd_nxt[p] = 1'b0;
		end
		if (st_r != ST_DATA)
			scr_nxt[p * 15 +: 15] = 15'h0;
	end
end
always @(posedge sys_clk_in or negedge rst_n_in)
begin
	if (!rst_n_in)
	begin
		st_r <= ST_OFF;
		mf_r <= 2'd0;
		oct_r <= 5'd0;
		fr_r <= 5'd0;
		mfo_r <= 10'd0;
		rc_r <= 8'd0;
		zs_r <= 4'd0;
		prn_r <= `SLT_R_PRN;
		cur_r <= 112'h0;
		sym_r <= 40'h0;
		rd_r <= 4'h0;
		act_r <= 4'h0;
		scr_r <= 60'h0;
		prev_r <= 32'h0;
		b0_r <= 112'h0;
		b1_r <= 112'h0;
		cnt_r <= 2'd0;
		rdy_r <= 1'b0;
	end
	else if (ce_in)
	begin
		b0_r <= b0_nxt;
		b1_r <= b1_nxt;
		cnt_r <= cnt_nxt;
		rdy_r <= (cnt_nxt != 2'd2);
		sym_r <= sym_nxt;
		rd_r <= rd_nxt;
		act_r <= act_nxt;
		scr_r <= scr_nxt;
		prev_r <= prev_nxt;
		if (oct_r == 5'd0)
			cur_r <= samp_w;
		// Frame counters run free so the multiframe boundary stays fixed across phases
		oct_r <= oct_last ? 5'd0 : oct_r + 5'd1;
		mfo_r <= mf_end ? 10'd0 : mfo_r + 10'd1;
		if (oct_last)
		begin
			fr_r <= (fr_r == k_r) ? 5'd0 : fr_r + 5'd1;
			prn_r <= {prn_r[14:0], prn_r[15] ^ prn_r[13] ^ prn_r[12] ^ prn_r[10]};
			if (st_r == ST_DATA)
				zs_r <= (zs_r >= zstuff_ratio_in) ? 4'd0 : zs_r + 4'd1;
		end
		if (link_off)
		begin
			st_r <= ST_OFF;
			oct_r <= 5'd0;
			fr_r <= 5'd0;
			mfo_r <= 10'd0;
			zs_r <= 4'd0;
		end
		else
		begin
			case (st_r)
			ST_OFF: st_r <= ST_CGS;
			ST_CGS:
			begin
				if (!sync_req && mf_end)
				begin
					st_r <= (ilas_mode == 2'b01) ? ST_DATA : ST_ILAS;
					mf_r <= 2'd0;
					rc_r <= 8'd0;
					zs_r <= 4'd0;
				end
			end
			ST_ILAS:
			begin
				if (sync_req)
					st_r <= ST_CGS;
				else if (mf_end)
				begin
					mf_r <= mf_r + 2'd1;
					if (mf_r == `SLT_ILAS_MF)
					begin
						if (ilas_mode == 2'b10)
							st_r <= ST_ILAS;
						else if (ilas_mode == 2'b11 && rc_r < rep_r)
							rc_r <= rc_r + 8'd1;
						else
							st_r <= ST_DATA;
					end
				end
			end
			ST_DATA:
			begin
				if (sync_req)
					st_r <= ST_CGS;
			end
			default: st_r <= ST_OFF;
			endcase
		end
	end
end
assign sample_ready_out = rdy_r;
assign first_serial_lane_out = sym_r[9:0];
assign second_serial_lane_out = sym_r[19:10];
assign third_serial_lane_out = sym_r[29:20];
assign fourth_serial_lane_out = sym_r[39:30];
assign lane_enable_out = act_r;
assign link_state_out = st_r;
endmodule
`default_nettype wire

// ==== common/slt_defs.vh ====
// Purpose: Constants of the serial link transmit configuration block
// Assumes: 13-bit register address, 8-bit register data
// Notes: Included by the design file only
`ifndef SLT_DEFS_VH
`define SLT_DEFS_VH
// ****************
// Register offsets
// ****************
`define SLT_A_OUTFMT 13'h014
`define SLT_A_DRV 13'h015
`define SLT_A_LCTL 13'h142
`define SLT_A_MIR 13'h143
`define SLT_A_REP 13'h145
`define SLT_A_DEVID 13'h146
`define SLT_A_BANKID 13'h147
`define SLT_A_LANEID0 13'h148
`define SLT_A_LANEID1 13'h149
`define SLT_A_LANEID2 13'h14A
`define SLT_A_LANEID3 13'h14B
`define SLT_A_LCFG 13'h150
`define SLT_A_OPF 13'h151
`define SLT_A_FPM 13'h152
`define SLT_A_CPL 13'h153
`define SLT_A_BPS 13'h155
`define SLT_A_SOPT 13'h156
`define SLT_A_CWPF 13'h157
`define SLT_A_CHK0 13'h15A
`define SLT_A_CHK1 13'h15B
// ****************
// Field positions
// ****************
`define SLT_B_POLINV 2
`define SLT_B_SYNCINV 5
`define SLT_B_TAILPRN 6
`define SLT_B_LINKOFF 0
`define SLT_B_SCR 7
// ****************
// Reset values
// ****************
`define SLT_R_OUTFMT 8'h00
`define SLT_R_LCTL 8'h00
`define SLT_R_LCFG 8'h83
`define SLT_R_FPM 5'h1F
`define SLT_R_PRN 16'hACE1
// ****************
// Fixed link parameters and characters
// ****************
`define SLT_M_M1 8'h07
`define SLT_N_M1 5'h0D
`define SLT_NP_M1 5'h0F
`define SLT_CF 5'h00
`define SLT_K_R 8'h1C
`define SLT_K_A 8'h7C
`define SLT_K_Q 8'h9C
`define SLT_K_K 8'hBC
`define SLT_K_F 8'hFC
`define SLT_ILAS_MF 2'h3
`endif

// ==== testbench/slt_link_assertions.sv ====
// Purpose: Port level checks of the serial link transmitter
// Assumes: Symbol sets hold both disparities and the mirrored forms
// Notes: Guards of two cycles cover the one cycle symbol latency
`timescale 1ns/10ps
`default_nettype none
module slt_link_checker (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	input wire logic [12:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [1:0] link_state_out,
	input wire logic [3:0] lane_enable_out,
	input wire logic [9:0] first_serial_lane_out,
	input wire logic [9:0] second_serial_lane_out
);
	// *****
	// Properties
	// *****
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_read(a);
		ce_in && reg_rd_in && reg_addr_in == a;
	endsequence
	sequence s_cgs;
		(link_state_out == 2'h1) [*2];
	endsequence
	property p_read(a, v);
		s_read(a) |=> reg_rdata_out == v;
	endproperty
	chk_bps_fixed: assert property (p_read(13'h155, 8'h0F))
		else $error("bits per sample readback wrong");
	chk_cwpf_zero: assert property (p_read(13'h157, 8'h00))
		else $error("control word readback wrong");
	chk_cpl_fixed: assert property (p_read(13'h153, 8'h07))
		else $error("converter count readback wrong");
	chk_opf_range: assert property (s_read(13'h151) |=> reg_rdata_out inside {8'h03, 8'h07, 8'h0F})
		else $error("octets per frame readback wrong");
	chk_lane_groups: assert property (link_state_out != 2'h0 && $past(link_state_out) != 2'h0
		|-> lane_enable_out inside {4'h1, 4'h5, 4'hF})
		else $error("lane enable pattern wrong");
	chk_idle_silent: assert property (!lane_enable_out[1] |-> second_serial_lane_out == 10'h000)
		else $error("idle lane not silent");
	chk_off_dark: assert property (link_state_out == 2'h0 && $past(link_state_out) == 2'h0
		|-> lane_enable_out == 4'h0 && first_serial_lane_out == 10'h000)
		else $error("link off yet lanes active");
	chk_off_exit: assert property (link_state_out == 2'h0 |=> link_state_out inside {2'h0, 2'h1})
		else $error("link left off state wrongly");
	chk_cgs_comma: assert property (s_cgs |-> first_serial_lane_out inside
		{10'h0FA, 10'h305, 10'h17C, 10'h283})
		else $error("no comma during code group sync");
	chk_ilas_start: assert property (link_state_out == 2'h2 && $past(link_state_out) == 2'h1
		|=> first_serial_lane_out inside {10'h0F4, 10'h30B, 10'h0BC, 10'h343})
		else $error("alignment sequence start wrong");
endmodule
bind slt_serial_link_tx slt_link_checker u_chk (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.link_state_out(link_state_out), .lane_enable_out(lane_enable_out),
	.first_serial_lane_out(first_serial_lane_out), .second_serial_lane_out(second_serial_lane_out));
`default_nettype wire

// ==== testbench/slt_rx_model.sv ====
// Purpose: Link receiver that requests and releases sync
// Assumes: Four commas on the first lane suffice, not necessarily in a row; other non-silent symbols leave the count as it is
// Notes: Short comma count keeps the run brief; a silent lane restarts the count
`timescale 1ns/10ps
`default_nettype none
module slt_rx_model (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [9:0] lane_in,
	input wire logic high_active_in,
	output logic sync_out
);
	logic [2:0] comma_cnt_r;
	logic req;
	always @(posedge sys_clk_in or negedge rst_n_in)
		if (!rst_n_in)
			comma_cnt_r <= 3'h0;
		else if (lane_in == 10'h000)
			comma_cnt_r <= 3'h0;
		else if (lane_in inside {10'h0FA, 10'h305, 10'h17C, 10'h283} && comma_cnt_r != 3'h4)
			comma_cnt_r <= comma_cnt_r + 3'h1;
	assign req = comma_cnt_r != 3'h4;
	assign sync_out = high_active_in ? req : !req;
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: Self checking bench of the serial link transmitter
// Assumes: Strobes one cycle wide, read data valid one edge later
// Notes: Clock enable held high, zero stuffer off, constant samples
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic sys_clk_in, rst_n_in, reg_wr_in, reg_rd_in, sample_valid_in, high_active, sync_req;
	logic sample_ready_out;
	logic [12:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	logic [9:0] lane1, lane2, lane3, lane4, m;
	logic [3:0] lane_enable_out;
	logic [1:0] link_state_out;
	logic [7:0] cfg_t [3] = '{8'h80, 8'h81, 8'h03};
	logic [7:0] opf_t [3] = '{8'h0F, 8'h07, 8'h03};
	logic [3:0] en_t [3] = '{4'h1, 4'h5, 4'hF};
	int miscompares, comparisons, cycles, nf, na, ilas_n;
	slt_serial_link_tx u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(1'h1),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sample_data_in({8{14'h0ABC}}),
		.sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
		.sync_request_input_in(sync_req), .zstuff_ratio_in(4'h0), .first_serial_lane_out(lane1),
		.second_serial_lane_out(lane2), .third_serial_lane_out(lane3), .fourth_serial_lane_out(lane4),
		.lane_enable_out(lane_enable_out), .link_state_out(link_state_out));
	slt_rx_model u_rx (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .lane_in(lane1),
		.high_active_in(high_active), .sync_out(sync_req));
	// *****
	// Tasks
	// *****
	task automatic tally_and_finish();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input [15:0] seen, input [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input [12:0] a, input [7:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'h1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'h0;
	endtask
	task automatic rd(input [12:0] a, input [7:0] e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'h1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'h0;
		@(negedge sys_clk_in);
		chk(reg_rdata_out, e);
	endtask
	// Bounded wait; also counts cycles spent in the alignment sequence
	task automatic wait_state(input [1:0] s);
		int n;
		n = 0;
		while (link_state_out !== s && n < 3000)
		begin
			@(negedge sys_clk_in);
			ilas_n += (link_state_out === 2'h2);
			n++;
		end
		chk(link_state_out, s);
	endtask
	// One multiframe of 128 octets on the first lane: 32 frame ends
	task automatic marks(input mir);
		nf = 0;
		na = 0;
		repeat (200) @(negedge sys_clk_in);
		repeat (128)
		begin
			@(negedge sys_clk_in);
			m = lane1;
			if (mir)
				m = {<<{lane1}};
			nf += m inside {10'h0F8, 10'h307};
			na += m inside {10'h0F3, 10'h30C};
		end
	endtask
	function automatic [7:0] config_checksum(input [4:0] lane1_ident_value, input scramble_enable_flag);
		config_checksum = 8'h12 + 8'h03 + lane1_ident_value + scramble_enable_flag + 8'h03 + 8'h03 + 8'h1F + 8'h07 + 8'h0D + 8'h0F;
	endfunction
	// *****
	// Stimulus
	// *****
	initial
	begin
		sys_clk_in = 1'h0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	initial
	begin
		{rst_n_in, reg_wr_in, reg_rd_in, sample_valid_in, high_active} = 5'h00;
		reg_addr_in = 13'h0000;
		reg_wdata_in = 8'h00;
		repeat (12) @(posedge sys_clk_in);
		rst_n_in <= 1'h1;
		rd(13'h014, 8'h00);
		rd(13'h142, 8'h00);
		rd(13'h143, 8'h00);
		rd(13'h145, 8'h00);
		rd(13'h150, 8'h83);
		rd(13'h152, 8'h1F);
		rd(13'h151, 8'h03);
		rd(13'h156, 8'h00);
		rd(13'h154, 8'h00);
		rd(13'h153, 8'h07);
		rd(13'h155, 8'h0F);
		rd(13'h157, 8'h00);
		wr(13'h142, 8'h01);
		wr(13'h146, 8'h12);
		wr(13'h147, 8'hF3);
		wr(13'h148, 8'hE5);
		wr(13'h149, 8'h06);
		wr(13'h145, 8'h02);
		wr(13'h151, 8'hFF);
		wr(13'h152, 8'hE7);
		rd(13'h146, 8'h12);
		rd(13'h147, 8'h03);
		rd(13'h148, 8'h05);
		rd(13'h145, 8'h02);
		rd(13'h151, 8'h03);
		rd(13'h152, 8'h07);
		wr(13'h152, 8'h1F);
		for (int i = 0; i < 3; i++)
		begin
			wr(13'h142, 8'h01);
			repeat (3) @(negedge sys_clk_in);
			chk(link_state_out, 2'h0);
			chk(lane_enable_out, 4'h0);
			wr(13'h150, cfg_t[i]);
			rd(13'h151, opf_t[i]);
			wr(13'h142, 8'h00);
			wait_state(2'h1);
			repeat (4) @(negedge sys_clk_in);
			chk(lane_enable_out, en_t[i]);
			chk(lane3 inside {10'h0FA, 10'h305}, i > 0);
			chk(lane4 inside {10'h0FA, 10'h305}, i == 2);
		end
		rd(13'h15A, config_checksum(5'h05, 1'h0));
		rd(13'h15B, config_checksum(5'h06, 1'h0));
		ilas_n = 0;
		wait_state(2'h3);
		chk(ilas_n, 512);
		marks(1'h0);
		chk(nf, 31);
		chk(na, 1);
		wr(13'h143, 8'h01);
		marks(1'h1);
		chk(nf, 31);
		wr(13'h143, 8'h00);
		wr(13'h142, 8'h01);
		wr(13'h142, 8'h04);
		ilas_n = 0;
		wait_state(2'h3);
		chk(ilas_n, 0);
		marks(1'h0);
		chk(nf, 32);
		chk(na, 0);
		// Counted repeats of the alignment sequence, then scrambled all-zero data
		wr(13'h142, 8'h01);
		wr(13'h150, 8'h83);
		wr(13'h142, 8'h0C);
		ilas_n = 0;
		wait_state(2'h3);
		chk(ilas_n, 1536);
		marks(1'h0);
		chk(nf, 0);
		chk(na, 0);
		wr(13'h156, 8'h20);
		wait_state(2'h1);
		@(posedge sys_clk_in);
		sample_valid_in <= 1'h1;
		repeat (6) @(negedge sys_clk_in);
		chk(sample_ready_out, 1'h0);
		high_active <= 1'h1;
		wait_state(2'h3);
		@(posedge sys_clk_in iff sample_ready_out === 1'b1);
		sample_valid_in <= 1'h0;
		repeat (20) @(negedge sys_clk_in);
		chk(sample_ready_out, 1'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
